// ### core/rsc_cfg.svh
// register offsets, reset values, command and result codes, timing figures
// assumes includers compare these against 6-bit addresses and 8-bit data
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_OFF_STATUS        6'h01
`define RSC_OFF_STATE_CMD     6'h02
`define RSC_OFF_CTRL_ONE      6'h04
`define RSC_OFF_EXT_CTRL      6'h17

`define RSC_RST_CTRL_ONE      8'h20
`define RSC_RST_EXT_CTRL      8'h00
`define RSC_RST_CMD           5'h00
`define RSC_RST_RESULT        3'h0
`define RSC_EXT_CTRL_WR_MASK  8'hF6

`define RSC_CMD_NOP           5'h00
`define RSC_CMD_TX_START      5'h02
`define RSC_CMD_FORCED_OFF    5'h03
`define RSC_CMD_FORCED_SYNTH  5'h04
`define RSC_CMD_RX_ON         5'h06
`define RSC_CMD_OFF           5'h08
`define RSC_CMD_SYNTH_ON      5'h09
`define RSC_CMD_AACK_ON       5'h16
`define RSC_CMD_ARET_ON       5'h19

`define RSC_RES_SUCCESS       3'h0
`define RSC_RES_PENDING       3'h1
`define RSC_RES_WAIT_ACK      3'h2
`define RSC_RES_MEDIUM_BUSY   3'h3
`define RSC_RES_NO_ACK        3'h5
`define RSC_RES_INVALID       3'h7

`define RSC_CLK_PERIOD_NS     100
`define RSC_SYMBOL_TIME_NS    16000
`define RSC_SETTLE_TIME_NS    1000

`endif

// ### core/rsc_pkg.sv
// types shared by the radio state and command block
// assumes nothing beyond a SystemVerilog compiler
package rsc_pkg;

  typedef enum logic [4:0] {
    POWER_ON                     = 5'b00000,
    BUSY_RECEIVE                 = 5'b00001,
    BUSY_TRANSMIT                = 5'b00010,
    RX_LISTEN                    = 5'b00110,
    CLOCKED_OFF                  = 5'b01000,
    SYNTH_ON                     = 5'b01001,
    SLEEP_STATE                  = 5'b01111,
    AUTO_ACK_RECEIVE_BUSY        = 5'b10001,
    AUTO_RETRY_TRANSMIT_BUSY     = 5'b10010,
    AUTO_ACK_LISTENING           = 5'b10110,
    AUTO_RETRY_READY             = 5'b11001,
    LISTENING_UNCLOCKED          = 5'b11100,
    AUTO_ACK_LISTENING_UNCLOCKED = 5'b11101,
    AUTO_ACK_BUSY_UNCLOCKED      = 5'b11110,
    TRANSITION_PENDING           = 5'b11111
  } rsc_radio_state_t;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_SETTLE = 2'b01,
    ACT_NOW    = 2'b10,
    ACT_TX     = 2'b11
  } rsc_act_kind_t;

  typedef struct packed {
    rsc_act_kind_t    kind;
    rsc_radio_state_t dest;
  } rsc_cmd_act_t;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [5:0] addr;
    logic [7:0] wrData;
  } rsc_reg_req_t;

  typedef struct packed {
    logic       ampOutputEnable;
    logic       rxStartPinEnable;
    logic       autoFcsEnable;
    logic       receiverLowCurrentCtl;
    logic [1:0] spiCmdMode;
    logic       irqMaskMode;
    logic       irqPolarity;
  } rsc_ctrl_one_t;

  typedef struct packed {
    logic reservedHigh;
    logic listenBeforeTalkSelect;
    logic reservedTypeFilter;
    logic reservedTypeUpload;
    logic reservedThree;
    logic shortAckTurnaround;
    logic promiscuousEnable;
    logic reservedZero;
  } rsc_ext_ctrl_t;

  typedef struct packed {
    logic             channelCheckComplete;
    logic             channelCheckResult;
    logic             reservedFive;
    rsc_radio_state_t radioStateField;
  } rsc_status_t;

  typedef struct packed {
    logic [2:0] transactionResultField;
    logic [4:0] stateCommandField;
  } rsc_cmd_reg_t;

endpackage

// ### core/rsc_delay_timer.sv
// one-shot delay: done pulses DELAY cycles after the start edge
// assumes start and cancel are synchronous to clk; cancel wins over start
`timescale 1ns/1ps
`default_nettype none

module rsc_delay_timer #(
  parameter int unsigned DELAY = 1,
  parameter int unsigned CNT_W = 16
)(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic start,
  input  wire logic cancel,
  output var  logic busy_ff,
  output var  logic done_ff
);

  localparam logic [CNT_W-1:0] LOAD = CNT_W'(DELAY - 1);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             nxt_busy;
  logic             nxt_done;
  wire              expire = busy_ff && (cnt_ff == '0);

  initial begin
    if (DELAY < 1 || DELAY >= (2 ** CNT_W)) begin
      $error("delay does not fit the counter");
    end
  end

  assign nxt_cnt  = start ? LOAD : (busy_ff ? cnt_ff - 1'b1 : cnt_ff);
  assign nxt_busy = !cancel && (start || (busy_ff && !expire));
  assign nxt_done = !cancel && !start && expire;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

endmodule

`default_nettype wire

// ### core/rsc_top.sv
// radio state control: command field, state status, result code, controls
// assumes register requests and all event inputs are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"

// Function
// RULE1: status field shows the present radio state
// RULE2: extended state codes arise only in extended mode
// RULE3: host waits while a transition is pending
// RULE4: no register access while asleep
// RULE5: command write starts the encoded transition
// RULE6: auto ack and retry commands need extended mode
// RULE7: command field resets to no operation
// RULE8: transmission begins one symbol after start
// RULE9: forced synth-on refused in unclocked states
// RULE10: trigger pin rising edge starts some transitions
// RULE11: host confirms transitions by reading status
// RULE12: read-only result field in bits 7:5
// RULE13: result resets zero, procedures start at invalid
// RULE14: result holds until next frame transmission
// RULE15: host pulses trigger pin for slotted ack
// RULE16: ack with pending bit reports result one
// RULE17: auto checksum enable resets to one
// RULE18: first control register field layout, all writable
// RULE19: extended control layout, bits 3,0 read zero
// RULE20: status carries channel check done and result
// RULE21: reserved command codes leave state unchanged
module rsc_top
  import rsc_pkg::*;
#(
  parameter int unsigned SYMBOL_NS = `RSC_SYMBOL_TIME_NS,
  parameter int unsigned SETTLE_NS = `RSC_SETTLE_TIME_NS,
  parameter int unsigned CLK_NS    = `RSC_CLK_PERIOD_NS
)(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire rsc_reg_req_t     regReq,
  output var  logic [7:0]       regRdData_ff,
  output var  logic             regRdValid_ff,
  input  wire logic             sleepTriggerPin,
  input  wire logic             extendedModeEnable,
  input  wire logic             rxFrameStart,
  input  wire logic             rxFrameEnd,
  input  wire logic             txFrameEnd,
  input  wire logic             aretAckRcvd,
  input  wire logic             ackFramePending,
  input  wire logic             aretNoAck,
  input  wire logic             aretCcaFail,
  input  wire logic             aackReport,
  input  wire logic [2:0]       aackResult,
  input  wire logic             ccaStart,
  input  wire logic             ccaDone,
  input  wire logic             ccaIdle,
  output var  rsc_radio_state_t radioState_ff,
  output var  rsc_ctrl_one_t    ctrlOne_ff,
  output var  rsc_ext_ctrl_t    extCtrl_ff,
  output var  logic             txFrameBegin_ff,
  output var  logic             ackSlotGo_ff
);

  localparam int TMR_W      = 16;
  localparam int SYMBOL_CYC = int'((SYMBOL_NS + CLK_NS - 1) / CLK_NS);
  localparam int SETTLE_CYC = int'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  // the begin pulse is launched by the edge SYMBOL_CYC after the command
  localparam int TX_LAG     = SYMBOL_CYC + 1;

  initial begin
    if (SYMBOL_CYC < 1 || SETTLE_CYC < 1 || CLK_NS == 0) begin
      $error("timing figures must give at least one cycle");
    end
  end

  // unclocked states cannot take a forced synth-on, nor can a move to them
  function automatic logic clockedSt(input rsc_radio_state_t st);
    clockedSt = !(st inside {POWER_ON, SLEEP_STATE, LISTENING_UNCLOCKED,
                             AUTO_ACK_LISTENING_UNCLOCKED,
                             AUTO_ACK_BUSY_UNCLOCKED});
  endfunction

  function automatic rsc_cmd_act_t decodeCmd(
    input logic [4:0]       cmd,
    input rsc_radio_state_t st,
    input rsc_radio_state_t tgt,
    input logic             ext
  );
    rsc_cmd_act_t a;
    logic         idleSt;
    logic         clkOk;
    a      = '{kind: ACT_NONE, dest: st};
    idleSt = st inside {CLOCKED_OFF, SYNTH_ON, RX_LISTEN,
                        AUTO_ACK_LISTENING, AUTO_RETRY_READY};
    clkOk  = clockedSt(st) && !(st == TRANSITION_PENDING && !clockedSt(tgt));
    case (cmd)
      `RSC_CMD_TX_START: begin
        if (st == SYNTH_ON) begin
          a = '{kind: ACT_TX, dest: BUSY_TRANSMIT};
        end else if (st == AUTO_RETRY_READY) begin
          a = '{kind: ACT_TX, dest: AUTO_RETRY_TRANSMIT_BUSY};
        end
      end
      `RSC_CMD_FORCED_OFF: begin
        if (clkOk) begin
          a = '{kind: ACT_NOW, dest: CLOCKED_OFF};
        end
      end
      `RSC_CMD_FORCED_SYNTH: begin
        if (clkOk && st != POWER_ON) begin // RULE9
          a = '{kind: ACT_NOW, dest: SYNTH_ON};
        end
      end
      `RSC_CMD_RX_ON: begin
        if (idleSt) begin
          a = '{kind: ACT_SETTLE, dest: RX_LISTEN};
        end
      end
      `RSC_CMD_OFF: begin
        if (idleSt || st == POWER_ON) begin
          a = '{kind: ACT_SETTLE, dest: CLOCKED_OFF};
        end
      end
      `RSC_CMD_SYNTH_ON: begin
        if (idleSt) begin
          a = '{kind: ACT_SETTLE, dest: SYNTH_ON};
        end
      end
      `RSC_CMD_AACK_ON: begin
        if (idleSt && ext) begin // RULE6 RULE2
          a = '{kind: ACT_SETTLE, dest: AUTO_ACK_LISTENING};
        end
      end
      `RSC_CMD_ARET_ON: begin
        if (idleSt && ext) begin // RULE6 RULE2
          a = '{kind: ACT_SETTLE, dest: AUTO_RETRY_READY};
        end
      end
      default: a = '{kind: ACT_NONE, dest: st}; // RULE21
    endcase
    decodeCmd = a;
  endfunction

  rsc_radio_state_t target_ff;
  rsc_radio_state_t nxtState;
  rsc_radio_state_t nxtTarget;
  logic [4:0]       cmdField_ff;
  logic [2:0]       resultField_ff;
  logic [2:0]       nxt_result;
  logic             ccaDoneFlag_ff;
  logic             ccaResult_ff;
  logic             pinPrev_ff;
  logic             settleGo;
  logic             txGo;
  logic             cancel;
  logic             settleDone;
  logic             ackSlot;

  // the radio refuses the host interface while asleep
  wire accessOk  = radioState_ff != SLEEP_STATE; // RULE4
  wire rdTaken   = accessOk && regReq.rdEn;
  wire wrTaken   = accessOk && regReq.wrEn;
  wire cmdWrite  = wrTaken && regReq.addr == `RSC_OFF_STATE_CMD;
  wire ctrlWrite = wrTaken && regReq.addr == `RSC_OFF_CTRL_ONE;
  wire extWrite  = wrTaken && regReq.addr == `RSC_OFF_EXT_CTRL;
  wire pinRise   = sleepTriggerPin && !pinPrev_ff;
  wire pinFall   = !sleepTriggerPin && pinPrev_ff;
  wire aretEnd   = aretAckRcvd || aretNoAck || aretCcaFail;
  wire aackBusy  = radioState_ff inside {AUTO_ACK_RECEIVE_BUSY,
                                         AUTO_ACK_BUSY_UNCLOCKED};

  rsc_cmd_act_t cmdAct;
  assign cmdAct = decodeCmd(regReq.wrData[4:0], radioState_ff, target_ff,
                            extendedModeEnable); // RULE5

  wire cmdEffective = cmdWrite && cmdAct.kind != ACT_NONE;
  wire aretStart = txGo && nxtState == AUTO_RETRY_TRANSMIT_BUSY;
  wire aackStart = rxFrameStart && !cmdEffective &&
                   radioState_ff inside {AUTO_ACK_LISTENING,
                                         AUTO_ACK_LISTENING_UNCLOCKED};

  // status and command words assembled for reads
  rsc_status_t  statusWord;
  rsc_cmd_reg_t cmdWord;
  assign statusWord = '{channelCheckComplete: ccaDoneFlag_ff, // RULE20
                        channelCheckResult:   ccaResult_ff,
                        reservedFive:         1'b0,
                        radioStateField:      radioState_ff}; // RULE1
  assign cmdWord = '{transactionResultField: resultField_ff, // RULE12
                     stateCommandField:      cmdField_ff};

  wire [7:0] rdMux =
    (regReq.addr == `RSC_OFF_STATUS)    ? statusWord :
    (regReq.addr == `RSC_OFF_STATE_CMD) ? cmdWord :
    (regReq.addr == `RSC_OFF_CTRL_ONE)  ? ctrlOne_ff :
    (regReq.addr == `RSC_OFF_EXT_CTRL)  ? extCtrl_ff : 8'h00;

  // a pending transition ignores ordinary commands; only forced ones cut in
  always_comb begin
    nxtState  = radioState_ff;
    nxtTarget = target_ff;
    settleGo  = 1'b0;
    txGo      = 1'b0;
    cancel    = 1'b0;
    ackSlot   = 1'b0;
    if (cmdEffective) begin
      case (cmdAct.kind)
        ACT_SETTLE: begin
          nxtState  = TRANSITION_PENDING;
          nxtTarget = cmdAct.dest;
          settleGo  = 1'b1;
        end
        ACT_TX: begin
          nxtState = cmdAct.dest;
          txGo     = 1'b1;
        end
        default: begin
          nxtState = cmdAct.dest;
          cancel   = 1'b1;
        end
      endcase
    end else begin
      case (radioState_ff)
        TRANSITION_PENDING: if (settleDone) nxtState = target_ff;
        CLOCKED_OFF: if (pinRise) begin // RULE10
          nxtState  = TRANSITION_PENDING;
          nxtTarget = SLEEP_STATE;
          settleGo  = 1'b1;
        end
        SLEEP_STATE: if (pinFall) begin
          nxtState  = TRANSITION_PENDING;
          nxtTarget = CLOCKED_OFF;
          settleGo  = 1'b1;
        end
        SYNTH_ON: if (pinRise) begin // RULE10
          nxtState = BUSY_TRANSMIT;
          txGo     = 1'b1;
        end
        AUTO_RETRY_READY: if (pinRise) begin // RULE10
          nxtState = AUTO_RETRY_TRANSMIT_BUSY;
          txGo     = 1'b1;
        end
        RX_LISTEN: begin
          if (rxFrameStart) nxtState = BUSY_RECEIVE;
          else if (pinRise) nxtState = LISTENING_UNCLOCKED; // RULE10
        end
        LISTENING_UNCLOCKED: begin
          if (rxFrameStart) nxtState = BUSY_RECEIVE;
          else if (pinFall) nxtState = RX_LISTEN;
        end
        BUSY_RECEIVE: if (rxFrameEnd) nxtState = RX_LISTEN;
        BUSY_TRANSMIT: if (txFrameEnd) nxtState = SYNTH_ON;
        AUTO_ACK_LISTENING: begin
          if (rxFrameStart) nxtState = AUTO_ACK_RECEIVE_BUSY;
          else if (pinRise) nxtState = AUTO_ACK_LISTENING_UNCLOCKED;
        end
        AUTO_ACK_LISTENING_UNCLOCKED: begin
          if (rxFrameStart) nxtState = AUTO_ACK_BUSY_UNCLOCKED;
          else if (pinFall) nxtState = AUTO_ACK_LISTENING;
        end
        AUTO_ACK_RECEIVE_BUSY, AUTO_ACK_BUSY_UNCLOCKED: begin
          // a slotted ack waits for the host's pin pulse at the slot edge
          if (pinRise && resultField_ff == `RSC_RES_WAIT_ACK) begin // RULE15
            ackSlot  = 1'b1;
            nxtState = AUTO_ACK_LISTENING;
          end else if (aackReport && aackResult != `RSC_RES_WAIT_ACK) begin
            nxtState = (radioState_ff == AUTO_ACK_RECEIVE_BUSY) ?
                       AUTO_ACK_LISTENING : AUTO_ACK_LISTENING_UNCLOCKED;
          end
        end
        AUTO_RETRY_TRANSMIT_BUSY: if (aretEnd) nxtState = AUTO_RETRY_READY;
        default: nxtState = radioState_ff;
      endcase
    end
  end

  // result changes only at procedure start, a wait-ack report or procedure end, so it holds till the next retry tx or auto-ack frame reception
  assign nxt_result =
    (aretStart || aackStart) ? `RSC_RES_INVALID : // RULE13 RULE14
    (radioState_ff == AUTO_RETRY_TRANSMIT_BUSY && !cancel && aretAckRcvd) ?
      (ackFramePending ? `RSC_RES_PENDING : `RSC_RES_SUCCESS) : // RULE16
    (radioState_ff == AUTO_RETRY_TRANSMIT_BUSY && !cancel && aretNoAck) ?
      `RSC_RES_NO_ACK :
    (radioState_ff == AUTO_RETRY_TRANSMIT_BUSY && !cancel && aretCcaFail) ?
      `RSC_RES_MEDIUM_BUSY :
    (aackBusy && !cancel && aackReport) ? aackResult :
    ackSlot ? `RSC_RES_SUCCESS : resultField_ff;

  rsc_delay_timer #(.DELAY(SETTLE_CYC), .CNT_W(TMR_W)) u_settle (
    .clk     (clk),
    .reset   (reset),
    .start   (settleGo),
    .cancel  (cancel),
    .busy_ff (),
    .done_ff (settleDone)
  );

  rsc_delay_timer #(.DELAY(SYMBOL_CYC), .CNT_W(TMR_W)) u_symbol (
    .clk     (clk),
    .reset   (reset),
    .start   (txGo),
    .cancel  (cancel),
    .busy_ff (),
    .done_ff (txFrameBegin_ff) // RULE8
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      radioState_ff  <= POWER_ON;
      target_ff      <= POWER_ON;
      resultField_ff <= `RSC_RST_RESULT; // RULE13
      pinPrev_ff     <= 1'b0;
      ackSlotGo_ff   <= 1'b0;
    end else begin
      radioState_ff  <= nxtState;
      target_ff      <= nxtTarget;
      resultField_ff <= nxt_result;
      pinPrev_ff     <= sleepTriggerPin;
      ackSlotGo_ff   <= ackSlot;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmdField_ff <= `RSC_RST_CMD; // RULE7
      ctrlOne_ff  <= `RSC_RST_CTRL_ONE; // RULE17
      extCtrl_ff  <= `RSC_RST_EXT_CTRL;
    end else begin
      if (cmdWrite) cmdField_ff <= regReq.wrData[4:0];
      if (ctrlWrite) ctrlOne_ff <= regReq.wrData; // RULE18
      if (extWrite) extCtrl_ff <= regReq.wrData & `RSC_EXT_CTRL_WR_MASK; // RULE19
    end
  end

  // a completion in the same cycle as a new check keeps the flag set
  always_ff @(posedge clk) begin
    if (reset) begin
      ccaDoneFlag_ff <= 1'b0;
      ccaResult_ff   <= 1'b0;
      regRdData_ff   <= 8'h00;
      regRdValid_ff  <= 1'b0;
    end else begin
      ccaDoneFlag_ff <= ccaDone || (ccaDoneFlag_ff && !ccaStart); // RULE20
      if (ccaDone) ccaResult_ff <= ccaIdle;
      regRdValid_ff <= rdTaken;
      if (rdTaken) regRdData_ff <= rdMux;
    end
  end

  a_sleep_no_read: assert property (@(posedge clk) disable iff (reset) // RULE4
    radioState_ff == SLEEP_STATE |=> !regRdValid_ff)
    else $error("register answered while asleep");
  a_status_reads: assert property (@(posedge clk) disable iff (reset) // RULE1
    rdTaken && regReq.addr == `RSC_OFF_STATUS |=>
      regRdValid_ff && regRdData_ff[4:0] == $past(radioState_ff))
    else $error("status read does not show the radio state");
  a_cmd_reset: assert property (@(posedge clk) // RULE7
    reset |=> cmdField_ff == `RSC_RST_CMD && resultField_ff == `RSC_RST_RESULT)
    else $error("command or result not cleared by reset");
  a_fcs_reset: assert property (@(posedge clk) // RULE17
    reset |=> ctrlOne_ff.autoFcsEnable && !ctrlOne_ff.ampOutputEnable)
    else $error("first control register reset value wrong");
  a_tx_one_symbol: assert property (@(posedge clk) disable iff (reset || cancel) // RULE8
    txGo |-> ##TX_LAG txFrameBegin_ff)
    else $error("transmission did not begin one symbol after start");
  a_ext_cmd_gate: assert property (@(posedge clk) disable iff (reset) // RULE6
    cmdWrite && !extendedModeEnable &&
    regReq.wrData[4:0] inside {`RSC_CMD_AACK_ON, `RSC_CMD_ARET_ON}
      |=> radioState_ff == $past(radioState_ff))
    else $error("extended command accepted outside extended mode");
  a_reserved_cmd: assert property (@(posedge clk) disable iff (reset) // RULE21
    cmdWrite && !(regReq.wrData[4:0] inside {`RSC_CMD_NOP, `RSC_CMD_TX_START,
      `RSC_CMD_FORCED_OFF, `RSC_CMD_FORCED_SYNTH, `RSC_CMD_RX_ON, `RSC_CMD_OFF,
      `RSC_CMD_SYNTH_ON, `RSC_CMD_AACK_ON, `RSC_CMD_ARET_ON})
      |=> $stable(radioState_ff))
    else $error("reserved command changed the state");
  a_forced_synth_bad: assert property (@(posedge clk) disable iff (reset) // RULE9
    cmdWrite && regReq.wrData[4:0] == `RSC_CMD_FORCED_SYNTH &&
    !clockedSt(radioState_ff) |=> radioState_ff == $past(radioState_ff))
    else $error("forced synth-on taken in an unclocked state");
  a_aret_invalid: assert property (@(posedge clk) disable iff (reset) // RULE13
    aretStart |=> resultField_ff == `RSC_RES_INVALID &&
                  radioState_ff == AUTO_RETRY_TRANSMIT_BUSY)
    else $error("retry procedure did not start at invalid");
  a_pending_ack: assert property (@(posedge clk) disable iff (reset) // RULE16
    radioState_ff == AUTO_RETRY_TRANSMIT_BUSY && !cmdEffective &&
    aretAckRcvd && ackFramePending |=>
      resultField_ff == `RSC_RES_PENDING && radioState_ff == AUTO_RETRY_READY)
    else $error("pending ack not reported as result one");
  a_ext_reserved: assert property (@(posedge clk) disable iff (reset) // RULE19
    extWrite |=> !extCtrl_ff.reservedThree && !extCtrl_ff.reservedZero)
    else $error("reserved extended control bits set");

  c_tx_start: cover property (@(posedge clk) disable iff (reset)
    txGo ##[1:300] txFrameBegin_ff);
  c_aret_pending: cover property (@(posedge clk) disable iff (reset)
    aretStart ##[1:500] resultField_ff == `RSC_RES_PENDING);
  c_sleep_entry: cover property (@(posedge clk) disable iff (reset)
    radioState_ff == CLOCKED_OFF && pinRise ##[1:50] radioState_ff == SLEEP_STATE);
  c_slot_ack: cover property (@(posedge clk) disable iff (reset)
    ackSlotGo_ff);

endmodule

`default_nettype wire

// ### testbench/rsc_radio_core_model.sv
// radio core stand-in: ends every transmitted frame a few cycles later
// assumes txBegin is a one-cycle pulse in the clk domain
`timescale 1ns/1ps
`default_nettype none
module rsc_radio_core_model #(
  parameter int unsigned FRAME_CYC = 4
)(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic txBegin,
  output var  logic txEnd_ff
);
  logic [7:0] cnt_ff;
  // short frames keep the run brief; real frames last far longer
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_ff   <= 8'h00;
      txEnd_ff <= 1'b0;
    end else begin
      txEnd_ff <= (cnt_ff == 8'h01);
      if (txBegin)
        cnt_ff <= FRAME_CYC[7:0];
      else if (cnt_ff != 8'h00)
        cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the radio state and command block
// assumes the radio core model closes every transmitted frame
`timescale 1ns/1ps
`default_nettype none
module tb_top import rsc_pkg::*;;
  logic             clk;
  logic             reset;
  rsc_reg_req_t     regReq;
  logic [7:0]       rdData;
  logic             rdValid;
  logic             pin;
  logic             extMode;
  logic             txEnd;
  logic [6:0]       ev;
  rsc_radio_state_t state;
  logic             txBegin;
  // rxEv: aackResult[2:0], aackReport, rxFrameEnd, rxFrameStart
  logic [5:0]       rxEv;
  rsc_ctrl_one_t    ctrlOne;
  rsc_ext_ctrl_t    extCtrl;
  logic             slotGo;
  int               bad_count;
  int               check_count;

  // ev: ccaFail, noAck, ccaStart, ccaDone, ccaIdle, ackRcvd, ackPending
  rsc_top #(.SYMBOL_NS(300), .SETTLE_NS(200)) uut (
    .clk(clk), .reset(reset), .regReq(regReq), .regRdData_ff(rdData),
    .regRdValid_ff(rdValid), .sleepTriggerPin(pin),
    .extendedModeEnable(extMode), .rxFrameStart(rxEv[0]),
    .rxFrameEnd(rxEv[1]), .txFrameEnd(txEnd), .aretAckRcvd(ev[1]),
    .ackFramePending(ev[0]), .aretNoAck(ev[5]), .aretCcaFail(ev[6]),
    .aackReport(rxEv[2]), .aackResult(rxEv[5:3]), .ccaStart(ev[4]),
    .ccaDone(ev[3]), .ccaIdle(ev[2]), .radioState_ff(state),
    .ctrlOne_ff(ctrlOne), .extCtrl_ff(extCtrl),
    .txFrameBegin_ff(txBegin), .ackSlotGo_ff(slotGo));

  rsc_radio_core_model core (
    .clk(clk), .reset(reset), .txBegin(txBegin), .txEnd_ff(txEnd));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk) #5 regReq = '{1'b1, 1'b0, a, d};
    @(posedge clk) #5 regReq = '0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic v);
    @(posedge clk) #5 regReq = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) #5 regReq = '0;
    chk({7'h00, rdValid}, {7'h00, v});
    if (v)
      chk(rdData, e);
  endtask

  // polling the state stands in for the host reading status after commands
  task automatic waitSt(input rsc_radio_state_t s);
    int n;
    n = 0;
    while (state !== s && n < 40) begin
      @(posedge clk) #5 n++;
    end
    chk({3'h0, state}, {3'h0, s});
  endtask

  task automatic pulse(input logic [6:0] v);
    @(posedge clk) #5 ev = v;
    @(posedge clk) #5 ev = '0;
  endtask

  task automatic rxPulse(input logic [5:0] v);
    @(posedge clk) #5 rxEv = v;
    @(posedge clk) #5 rxEv = '0;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // the sequence needs under two hundred cycles; this 20000-cycle limit allows a hundred times more
  initial begin
    #2000000;
    bad_count++;
    end_of_test();
  end

  initial begin
    int n;
    reset = 1'b1;
    regReq = '0;
    pin = 1'b0;
    extMode = 1'b0;
    ev = '0;
    rxEv = '0;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    #5 reset = 1'b0;
    rd(6'h01, 8'h00, 1'b1);
    rd(6'h02, 8'h00, 1'b1);
    rd(6'h04, 8'h20, 1'b1);
    rd(6'h17, 8'h00, 1'b1);
    wr(6'h17, 8'hFF);
    rd(6'h17, 8'hF6, 1'b1);
    chk(extCtrl, 8'hF6);
    wr(6'h04, 8'hDF);
    rd(6'h04, 8'hDF, 1'b1);
    chk(ctrlOne, 8'hDF);
    wr(6'h02, 8'h04);
    rd(6'h01, 8'h00, 1'b1);
    // each accepted settling command waits for the settled state before the next one
    wr(6'h02, 8'h08);
    chk({3'h0, state}, 8'h1F);
    waitSt(CLOCKED_OFF);
    wr(6'h02, 8'h05);
    rd(6'h02, 8'h05, 1'b1);
    chk({3'h0, state}, 8'h08);
    wr(6'h02, 8'h16);
    rd(6'h01, 8'h08, 1'b1);
    pulse(7'h0C);
    rd(6'h01, 8'hC8, 1'b1);
    pulse(7'h10);
    rd(6'h01, 8'h48, 1'b1);
    @(posedge clk) #5 pin = 1'b1;
    waitSt(SLEEP_STATE);
    rd(6'h01, 8'h00, 1'b0);
    @(posedge clk) #5 pin = 1'b0;
    waitSt(CLOCKED_OFF);
    wr(6'h02, 8'h06);
    waitSt(RX_LISTEN);
    rxPulse(6'h01);
    chk({3'h0, state}, 8'h01);
    rxPulse(6'h02);
    chk({3'h0, state}, 8'h06);
    wr(6'h02, 8'h09);
    waitSt(SYNTH_ON);
    wr(6'h02, 8'h02);
    chk({3'h0, state}, 8'h02);
    n = 0;
    while (txBegin !== 1'b1 && n < 40) begin
      @(posedge clk) #5 n++;
    end
    chk(8'(n), 8'h03);
    waitSt(SYNTH_ON);
    extMode = 1'b1;
    wr(6'h02, 8'h19);
    waitSt(AUTO_RETRY_READY);
    wr(6'h02, 8'h02);
    rd(6'h02, 8'hE2, 1'b1);
    pulse(7'h03);
    rd(6'h02, 8'h22, 1'b1);
    chk({3'h0, state}, 8'h19);
    wr(6'h02, 8'h02);
    pulse(7'h20);
    rd(6'h02, 8'hA2, 1'b1);
    wr(6'h02, 8'h02);
    pulse(7'h40);
    repeat (6) @(posedge clk);
    rd(6'h02, 8'h62, 1'b1);
    wr(6'h02, 8'h16);
    waitSt(AUTO_ACK_LISTENING);
    rxPulse(6'h01);
    rd(6'h02, 8'hF6, 1'b1);
    rxPulse(6'h14);
    rd(6'h02, 8'h56, 1'b1);
    @(posedge clk) #5 pin = 1'b1;
    @(posedge clk) #5 chk({7'h00, slotGo}, 8'h01);
    pin = 1'b0;
    chk({3'h0, state}, 8'h16);
    rd(6'h02, 8'h16, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
